/* File: pil_pkg.sv */
// shared constants for the port indicator control block
package pil_pkg;
	localparam int PIL_CLK_HZ = 50_000_000;
	localparam int PIL_UNIT_MS = 10;
	localparam int PIL_UNIT_CYC = PIL_CLK_HZ / 1000 * PIL_UNIT_MS;
	localparam int PIL_PORTS = 9;
	localparam logic [3:0] PIL_POST_LAST = 4'h8;
	// register indices; byte address is four times the index
	localparam int PIL_IDX_CFG = 'h0f;
	localparam int PIL_IDX_SETA = 'h10;
	localparam int PIL_IDX_SETB = 'h12;
	localparam int PIL_IDX_FSEL = 'h14;
	localparam int PIL_IDX_EN = 'h16;
	localparam logic [7:0] PIL_ADDR_CFG = 8'(PIL_IDX_CFG * 4);
	localparam logic [7:0] PIL_ADDR_SETA = 8'(PIL_IDX_SETA * 4);
	localparam logic [7:0] PIL_ADDR_SETB = 8'(PIL_IDX_SETB * 4);
	localparam logic [7:0] PIL_ADDR_FSEL = 8'(PIL_IDX_FSEL * 4);
	localparam logic [7:0] PIL_ADDR_EN = 8'(PIL_IDX_EN * 4);
	// configuration fields
	localparam int PIL_CFG_GLOB = 7;
	localparam int PIL_CFG_RESTART = 6;
	localparam int PIL_CFG_SCAN = 5;
	// reset values
	localparam logic PIL_RST_GLOB = 1'h1;
	localparam logic [2:0] PIL_RST_PER = 3'h3;
	localparam logic [2:0] PIL_PER_MIN = 3'h1;
	localparam logic [15:0] PIL_RST_SET = 16'h2024;
	localparam logic [8:0] PIL_RST_FSEL = 9'h1ff;
	localparam logic [8:0] PIL_RST_EN = 9'h01f;
	localparam logic [8:0] PIL_PORT_USED = 9'h13f;
	localparam logic [15:0] PIL_SET_LINK_ONLY = 16'h4000;
	// link speed codes
	localparam logic [1:0] PIL_SPD_10 = 2'h0;
	localparam logic [1:0] PIL_SPD_1G = 2'h2;
endpackage

/* File: pil_ctl_if.sv */
// control and timing signals shared between the block's modules
`timescale 1ns/1ps
interface pil_ctl_if;
	logic [2:0] period_sel;
	logic blink;
	logic slow_blink;
	logic restart;
	logic scan_en;
	logic busy;
	logic [3:0] scan_idx;
	modport ctl (output period_sel, restart, scan_en,
		input blink, slow_blink, busy, scan_idx);
	modport blk (input period_sel, output blink, slow_blink);
	modport post (input restart, blink, output busy, scan_idx);
endinterface

/* File: pil_blink.sv */
// blink phase generator with selectable refresh period
`timescale 1ns/1ps
module pil_blink
	import pil_pkg::*;
#(
	parameter int UNIT_CYC = PIL_UNIT_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// timing to the rest of the block
	pil_ctl_if.blk b
);
	logic [19:0] unit_cnt_q;
	logic [2:0] units_q;
	logic [1:0] quad_q;
	logic blink_q;
	logic slow_q;
	wire unit_tick = (unit_cnt_q == 20'(UNIT_CYC - 1));
	// reserved code 000 behaves as 001
	wire [2:0] n_eff = (b.period_sel == 3'h0) ? PIL_PER_MIN : b.period_sel;
	wire period_end = unit_tick && (units_q == n_eff); // RULE_03
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			unit_cnt_q <= 20'h0;
			units_q <= 3'h0;
			quad_q <= 2'h0;
			blink_q <= 1'h0;
			slow_q <= 1'h0;
		end else begin
			unit_cnt_q <= unit_tick ? 20'h0 : unit_cnt_q + 20'h1;
			if (unit_tick)
				units_q <= period_end ? 3'h0 : units_q + 3'h1; // RULE_03
			if (period_end) begin
				blink_q <= ~blink_q;
				quad_q <= quad_q + 2'h1;
				if (quad_q == 2'h3)
					slow_q <= ~slow_q; // RULE_06
			end
		end
	end
	assign b.blink = blink_q;
	assign b.slow_blink = slow_q;
	chk_blink_period: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_03
		$changed(blink_q) |-> $past(units_q) == $past(n_eff) && $past(unit_tick))
		else $error("blink phase changed off the period boundary");
	chk_slow_quarter: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_06
		$changed(slow_q) |-> $changed(blink_q) && $past(quad_q) == 2'h3)
		else $error("slow blink not at a quarter of the blink rate");
endmodule

/* File: pil_post.sv */
// power-on self-test sequencer with port scan index
`timescale 1ns/1ps
module pil_post
	import pil_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// control and timing
	pil_ctl_if.post p
);
	logic busy_q;
	logic [3:0] idx_q;
	logic blink_prev_q;
	wire step = busy_q && (p.blink != blink_prev_q);
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			busy_q <= 1'h1;
			idx_q <= 4'h0;
			blink_prev_q <= 1'h0;
		end else begin
			blink_prev_q <= p.blink;
			if (p.restart) begin
				busy_q <= 1'h1; // RULE_01
				idx_q <= 4'h0;
			end else if (step) begin
				busy_q <= (idx_q != PIL_POST_LAST);
				idx_q <= (idx_q == PIL_POST_LAST) ? 4'h0 : idx_q + 4'h1; // RULE_02
			end
		end
	end
	assign p.busy = busy_q;
	assign p.scan_idx = idx_q;
	chk_post_end: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_02
		busy_q && step && idx_q == PIL_POST_LAST && !p.restart |=> !busy_q)
		else $error("self test did not end after the last port");
endmodule

/* File: pil_top.sv */
// port indicator configuration registers and indicator drive
// What this block does
// (RULE_01) writing one to the restart bit reruns the self test; bit reads zero
// (RULE_02) with scan enabled the self test walks across the ports, else lights all
// (RULE_03) blink period is (N+1) times ten ms; code 000 acts as 001
// (RULE_04) the period selector resets to 011, forty ms
// (RULE_05) each function-set bit except bits 7:6 enables one indicator source
// (RULE_06) link/activity (bit 12) blinks at quarter rate at 10M in automatic mode
// (RULE_07) per-port select bit picks set b when one, set a when zero
// (RULE_08) map bits 4:0 are ports 4:0; ports 5 and 8 go serially
// (RULE_09) per-port enable map gates each indicator; resets to 1f
// (RULE_10) software writes reserved bits as zero and ignores them on read
// (RULE_11) global enable resets to one; when clear every indicator is dark
`timescale 1ns/1ps
module pil_top
	import pil_pkg::*;
#(
	parameter int UNIT_CYC = PIL_UNIT_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o,
	// per-port link status from the switch core
	input wire logic [8:0] link_up_source_i,
	input wire logic [8:0] activity_source_i,
	input wire logic [8:0] duplex_source_i,
	input wire logic [8:0] collision_i,
	input wire logic [8:0] tsync_link_i,
	input wire logic [17:0] speed_i,
	input wire logic auto_mode_i,
	// indicator outputs
	output logic [4:0] par_led_o,
	output logic ser_data_o,
	output logic ser_port8_o
);
	// register state
	logic indicator_global_enable_q;
	logic self_test_restart_q;
	logic self_test_port_scan_enable_q;
	logic [2:0] blink_period_select_q;
	logic [15:0] indicator_function_set_a_q;
	logic [15:0] indicator_function_set_b_q;
	logic [8:0] port_function_select_q;
	logic [8:0] port_indicator_enable_q;
	// bus answer state
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	// indicator output state
	logic [4:0] par_q;
	logic ser_data_q;
	logic ser_sel_q;
	logic [8:0] lamp_d;

	pil_ctl_if ctl ();

	pil_blink #(
		.UNIT_CYC(UNIT_CYC)
	) u_blink (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.b(ctl.blk)
	);

	pil_post u_post (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.p(ctl.post)
	);

	assign ctl.period_sel = blink_period_select_q;
	assign ctl.restart = self_test_restart_q;
	assign ctl.scan_en = self_test_port_scan_enable_q;

	// source vector of one port, bit 15 down to bit 0
	function automatic logic [15:0] pil_sources(
		input logic link_up_source,
		input logic act,
		input logic duplex_source,
		input logic col,
		input logic ts,
		input logic [1:0] spd,
		input logic blk,
		input logic slow,
		input logic auto
	);
		logic s10;
		logic s100;
		logic s1g;
		logic ab;
		logic as;
		s10 = (spd == PIL_SPD_10);
		s1g = (spd == PIL_SPD_1G);
		s100 = spd[0];
		ab = act & blk;
		as = act & ((auto & s10) ? slow : blk); // RULE_06
		return {ts, link_up_source, link_up_source & ~ab, link_up_source & ~as, ab, // RULE_05
			s1g & link_up_source & ~ab, s100 & link_up_source & ~ab, s10 & link_up_source & ~ab,
			2'h0, duplex_source, duplex_source ^ (col & blk),
			s1g & link_up_source, s100 & link_up_source, s10 & link_up_source, col};
	endfunction

	// per-port indicator selection
	for (genvar i = 0; i < PIL_PORTS; i++) begin : g_port
		wire [15:0] src = pil_sources(link_up_source_i[i],
			activity_source_i[i], duplex_source_i[i], collision_i[i],
			tsync_link_i[i], speed_i[2*i+1:2*i], ctl.blink,
			ctl.slow_blink, auto_mode_i);
		wire [15:0] set = port_function_select_q[i] ? // RULE_07
			indicator_function_set_b_q : indicator_function_set_a_q;
		wire fn_on = |(src & set); // RULE_05
		wire post_on = !ctl.scan_en || // RULE_02
			(ctl.scan_idx == 4'(i));
		wire lit = ctl.busy ? post_on : fn_on;
		assign lamp_d[i] = indicator_global_enable_q && // RULE_11
			port_indicator_enable_q[i] && PIL_PORT_USED[i] && lit; // RULE_09
	end

	// bus decode
	wire acc = psel_i && penable_i;
	wire first_acc = acc && !pready_q;
	wire wr_take = acc && pready_q && pwrite_i;
	wire hit_cfg = (paddr_i == PIL_ADDR_CFG);
	wire hit_seta = (paddr_i == PIL_ADDR_SETA);
	wire hit_setb = (paddr_i == PIL_ADDR_SETB);
	wire hit_fsel = (paddr_i == PIL_ADDR_FSEL);
	wire hit_en = (paddr_i == PIL_ADDR_EN);
	wire hit_any = hit_cfg || hit_seta || hit_setb || hit_fsel || hit_en;
	// write strobes, one per register
	wire we_cfg = wr_take && hit_cfg;
	wire we_seta = wr_take && hit_seta;
	wire we_setb = wr_take && hit_setb;
	wire we_fsel = wr_take && hit_fsel;
	wire we_en = wr_take && hit_en;
	wire [7:0] cfg_rd = {indicator_global_enable_q, self_test_restart_q,
		self_test_port_scan_enable_q, 2'h0, blink_period_select_q}; // RULE_10
	wire [31:0] rd_word =
		hit_cfg ? {24'h0, cfg_rd} :
		hit_seta ? {16'h0, indicator_function_set_a_q} :
		hit_setb ? {16'h0, indicator_function_set_b_q} :
		hit_fsel ? {23'h0, port_function_select_q} :
		hit_en ? {23'h0, port_indicator_enable_q} : 32'h0;

	// bus answer: one wait state, data and error registered
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pready_q <= 1'h0;
			pslverr_q <= 1'h0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= first_acc;
			pslverr_q <= first_acc && !hit_any;
			prdata_q <= (first_acc && !pwrite_i) ? rd_word : 32'h0;
		end
	end

	// configuration register
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			indicator_global_enable_q <= PIL_RST_GLOB; // RULE_11
			self_test_restart_q <= 1'h0;
			self_test_port_scan_enable_q <= 1'h0;
			blink_period_select_q <= PIL_RST_PER; // RULE_04
		end else begin
			self_test_restart_q <= we_cfg && pwdata_i[PIL_CFG_RESTART]; // RULE_01
			if (we_cfg) begin
				indicator_global_enable_q <= pwdata_i[PIL_CFG_GLOB];
				self_test_port_scan_enable_q <= pwdata_i[PIL_CFG_SCAN];
				blink_period_select_q <= pwdata_i[2:0]; // RULE_03
			end
		end
	end

	// function set a
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			indicator_function_set_a_q <= PIL_RST_SET;
		end else if (we_seta) begin
			indicator_function_set_a_q <= pwdata_i[15:0]; // RULE_05
		end
	end

	// function set b
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			indicator_function_set_b_q <= PIL_RST_SET;
		end else if (we_setb) begin
			indicator_function_set_b_q <= pwdata_i[15:0]; // RULE_05
		end
	end

	// per-port function select
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			port_function_select_q <= PIL_RST_FSEL; // RULE_07
		end else if (we_fsel) begin
			port_function_select_q <= pwdata_i[8:0]; // RULE_07
		end
	end

	// per-port enable map
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			port_indicator_enable_q <= PIL_RST_EN; // RULE_09
		end else if (we_en) begin
			port_indicator_enable_q <= pwdata_i[8:0]; // RULE_09
		end
	end

	// parallel lamps for ports 4:0
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			par_q <= 5'h0;
		end else begin
			par_q <= lamp_d[4:0]; // RULE_08
		end
	end

	// serial pair: slot flag toggles, port 8 rides in the flagged slot
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ser_data_q <= 1'h0;
			ser_sel_q <= 1'h0;
		end else begin
			ser_sel_q <= ~ser_sel_q;
			ser_data_q <= ser_sel_q ? lamp_d[5] : lamp_d[8]; // RULE_08
		end
	end

	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign prdata_o = prdata_q;
	assign par_led_o = par_q;
	assign ser_data_o = ser_data_q;
	assign ser_port8_o = ser_sel_q;

	// checks
	sequence s_restart_wr;
		wr_take && hit_cfg && pwdata_i[PIL_CFG_RESTART];
	endsequence
	sequence s_post_begin;
		self_test_restart_q ##1 (ctl.busy && ctl.scan_idx == 4'h0 &&
			!self_test_restart_q);
	endsequence
	chk_restart_post: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_01
		s_restart_wr |=> s_post_begin)
		else $error("restart write did not rerun the self test");
	chk_scan_dark: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_02
		ctl.busy && self_test_port_scan_enable_q && ctl.scan_idx != 4'h0
		|=> !par_led_o[0])
		else $error("scan lit a port other than the scanned one");
	chk_post_all_lit: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_02
		ctl.busy && !self_test_port_scan_enable_q && indicator_global_enable_q
		&& port_indicator_enable_q[0] |=> par_led_o[0])
		else $error("self test without scan left port 0 dark");
	chk_period_reset: assert property (@(posedge clk_i) // RULE_04
		resetn_i && !$past(resetn_i) |-> blink_period_select_q == PIL_RST_PER)
		else $error("period selector reset value wrong");
	chk_map_reset: assert property (@(posedge clk_i) // RULE_07 RULE_09
		resetn_i && !$past(resetn_i) |-> port_function_select_q == PIL_RST_FSEL
		&& port_indicator_enable_q == PIL_RST_EN && indicator_global_enable_q)
		else $error("map reset values wrong");
	chk_func_select: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_07
		!ctl.busy && indicator_global_enable_q && port_indicator_enable_q[0]
		&& !port_function_select_q[0]
		&& indicator_function_set_a_q == PIL_SET_LINK_ONLY
		|=> par_led_o[0] == $past(link_up_source_i[0]))
		else $error("set a did not drive port 0");
	chk_port_disable: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_09
		!port_indicator_enable_q[2] |=> !par_led_o[2])
		else $error("disabled port lit");
	chk_global_off: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_11
		!indicator_global_enable_q |=> par_led_o == 5'h0 && !ser_data_o)
		else $error("indicator lit while globally disabled");
	chk_serial_order: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_08
		ser_port8_o |-> ser_data_o == $past(lamp_d[8]))
		else $error("serial slot does not carry port 8");
	chk_apb_answer: assert property (@(posedge clk_i) disable iff (!resetn_i)
		first_acc |=> pready_o ##1 !pready_o)
		else $error("apb answer not after one wait state");
	sequence s_cfg_read;
		first_acc && !pwrite_i && hit_cfg;
	endsequence
	chk_restart_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_01
		self_test_restart_q |=> !self_test_restart_q)
		else $error("restart bit did not clear itself");
	chk_scan_lands: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_02
		we_cfg |=> self_test_port_scan_enable_q == $past(pwdata_i[PIL_CFG_SCAN]))
		else $error("scan enable write lost");
	chk_period_lands: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_03
		we_cfg |=> blink_period_select_q == $past(pwdata_i[2:0]))
		else $error("period select write lost");
	chk_glob_lands: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_11
		we_cfg |=> indicator_global_enable_q == $past(pwdata_i[PIL_CFG_GLOB]))
		else $error("global enable write lost");
	chk_period_read: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_04
		s_cfg_read |=> prdata_o[2:0] == $past(blink_period_select_q))
		else $error("period select read back wrong");
	chk_cfg_rsvd_read: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_10
		s_cfg_read |=> prdata_o[4:3] == 2'h0)
		else $error("reserved config bits read nonzero");
	chk_set_reset: assert property (@(posedge clk_i) // RULE_05
		resetn_i && !$past(resetn_i) |-> indicator_function_set_a_q == PIL_RST_SET
		&& indicator_function_set_b_q == PIL_RST_SET)
		else $error("function set reset values wrong");
	chk_seta_lands: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_05
		we_seta |=> indicator_function_set_a_q == $past(pwdata_i[15:0]))
		else $error("set a write lost");
	chk_setb_lands: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_05
		we_setb |=> indicator_function_set_b_q == $past(pwdata_i[15:0]))
		else $error("set b write lost");
	chk_fsel_lands: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_07
		we_fsel |=> port_function_select_q == $past(pwdata_i[8:0]))
		else $error("function select write lost");
	chk_en_lands: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_09
		we_en |=> port_indicator_enable_q == $past(pwdata_i[8:0]))
		else $error("enable map write lost");
	chk_unmapped_err: assert property (@(posedge clk_i) disable iff (!resetn_i)
		first_acc && !hit_any |=> pslverr_o && prdata_o == 32'h0)
		else $error("unmapped access not refused");
	chk_unmapped_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
		wr_take && !hit_any |=> $stable(indicator_function_set_a_q)
		&& $stable(port_indicator_enable_q) && $stable(blink_period_select_q))
		else $error("unmapped write changed a register");
	chk_prdata_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!pready_o |-> prdata_o == 32'h0)
		else $error("read data not zero outside the answer");
	chk_slot_toggle: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_08
		ser_port8_o |=> !ser_port8_o)
		else $error("serial slot flag did not alternate");
	chk_slot_port5: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_08
		$past(resetn_i) && !ser_port8_o |-> ser_data_o == $past(lamp_d[5]))
		else $error("serial slot does not carry port 5");
	chk_par_follow: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_08
		$past(resetn_i) |-> par_led_o == $past(lamp_d[4:0]))
		else $error("parallel lamps do not follow ports 4 to 0");
endmodule

/* File: pil_lamp_model.sv */
// serial indicator receiver holding the lamps of ports 5 and 8
`timescale 1ns/1ps
module pil_lamp_model (
	// clock
	input wire logic clk_i,
	// serial indicator stream
	input wire logic ser_data_i,
	input wire logic ser_port8_i,
	// lamp states
	output logic lamp5_o,
	output logic lamp8_o
);
	always @(posedge clk_i) begin
		if (ser_port8_i) begin
			lamp8_o <= ser_data_i;
		end else begin
			lamp5_o <= ser_data_i;
		end
	end
endmodule

/* File: port_indicator_led_control_bench.sv */
// self-checking bench for the port indicator control block
`timescale 1ns/1ps
module port_indicator_led_control_bench import pil_pkg::*;;
	localparam int UNIT = 4;
	logic clk_i, resetn_i, psel_i, penable_i, pwrite_i, auto_mode_i;
	logic pready_o, pslverr_o, ser_data_o, ser_port8_o, lamp5, lamp8, rerr;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rdata;
	logic [8:0] link_i, act_i, dpx_i, col_i, ts_i;
	logic [17:0] speed_i;
	logic [4:0] par_led_o, seen;
	int failures, cmp_count, multi, full, c;
	pil_top #(.UNIT_CYC(UNIT)) DUT (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
		.link_up_source_i(link_i), .activity_source_i(act_i), .duplex_source_i(dpx_i),
		.collision_i(col_i), .tsync_link_i(ts_i), .speed_i(speed_i),
		.auto_mode_i(auto_mode_i), .par_led_o(par_led_o), .ser_data_o(ser_data_o),
		.ser_port8_o(ser_port8_o));
	pil_lamp_model lamps (.clk_i(clk_i), .ser_data_i(ser_data_o), .ser_port8_i(ser_port8_o),
		.lamp5_o(lamp5), .lamp8_o(lamp8));
	task automatic print_verdict();
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		psel_i <= 1'h1;
		penable_i <= 1'h0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'h1 && n < 50);
		rdata = prdata_o;
		rerr = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		if (n >= 50) begin
			failures++;
			$display("wrong value t=%0t apb no answer", $time);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
		apb(1'h0, a, 32'h0);
		chk(rdata, e, m);
	endtask
	task automatic led(input logic [4:0] e, input logic [1:0] s, input string m);
		repeat (5) @(posedge clk_i);
		chk({25'h0, lamp8, lamp5, par_led_o}, {25'h0, s, e}, m);
	endtask
	task automatic fset(input logic [15:0] s, input logic [8:0] l, d, t,
		input logic [1:0] sp, input logic [4:0] e, input string m);
		link_i <= l;
		dpx_i <= d;
		ts_i <= t;
		speed_i <= {9{sp}};
		wr(PIL_ADDR_SETA, {16'h0, s});
		led(e, {2{e[0]}}, m);
	endtask
	// third interval between lamp changes, earlier ones may be partial
	task automatic span();
		logic v;
		repeat (3) begin
			v = par_led_o[0];
			c = 0;
			do begin
				@(posedge clk_i);
				c++;
			end while (par_led_o[0] === v && c < 500);
		end
	endtask
	task automatic watch();
		seen = 5'h0;
		multi = 0;
		full = 0;
		repeat (250) begin
			@(posedge clk_i);
			seen |= par_led_o;
			if ($countones(par_led_o) > 1) multi++;
			if (par_led_o === 5'h1f) full++;
		end
	endtask
	initial begin
		clk_i = 1'h0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		#(20000 * 20);
		failures++;
		print_verdict();
	end
	initial begin
		{resetn_i, psel_i, penable_i, pwrite_i, auto_mode_i} = 5'h0;
		{paddr_i, pwdata_i, speed_i} = '0;
		{link_i, act_i, dpx_i, col_i, ts_i} = '0;
		failures = 0;
		cmp_count = 0;
		repeat (5) @(posedge clk_i);
		resetn_i <= 1'h1;
		rd(PIL_ADDR_CFG, 32'h83, "cfg reset");
		rd(PIL_ADDR_SETA, 32'h2024, "set a reset");
		rd(PIL_ADDR_SETB, 32'h2024, "set b reset");
		rd(PIL_ADDR_FSEL, 32'h1ff, "select reset");
		rd(PIL_ADDR_EN, 32'h1f, "enable reset");
		rd(8'h44, 32'h0, "unmapped read");
		chk({31'h0, rerr}, 32'h1, "unmapped error");
		wr(8'h44, 32'h0);
		repeat (200) @(posedge clk_i);
		wr(PIL_ADDR_SETA, 32'h4000);
		wr(PIL_ADDR_SETB, 32'h4000);
		wr(PIL_ADDR_CFG, 32'he3);
		watch();
		rd(PIL_ADDR_CFG, 32'ha3, "restart reads zero");
		chk({27'h0, seen}, 32'h1f, "scan walk");
		chk(32'(multi + full), 32'h0, "scan one at a time");
		wr(PIL_ADDR_CFG, 32'hc3);
		watch();
		chk(32'(full > 0), 32'h1, "self test reruns");
		led(5'h0, 2'h0, "self test over");
		link_i <= 9'h1ff;
		wr(PIL_ADDR_EN, 32'h13f);
		rd(PIL_ADDR_EN, 32'h13f, "reserved map bits");
		led(5'h1f, 2'h3, "all enabled");
		wr(PIL_ADDR_EN, 32'h25);
		led(5'h05, 2'h1, "map gating");
		wr(PIL_ADDR_EN, 32'h13f);
		wr(PIL_ADDR_CFG, 32'h03);
		led(5'h0, 2'h0, "global off");
		wr(PIL_ADDR_CFG, 32'h83);
		wr(PIL_ADDR_SETB, 32'h0020);
		wr(PIL_ADDR_FSEL, 32'h10a);
		led(5'h15, 2'h1, "per-port select");
		wr(PIL_ADDR_FSEL, 32'h0);
		fset(16'h4000, 9'h1ff, 9'h0, 9'h0, 2'h0, 5'h1f, "link");
		fset(16'h0020, 9'h0, 9'h1ff, 9'h0, 2'h0, 5'h1f, "duplex");
		fset(16'h8000, 9'h0, 9'h0, 9'h1ff, 2'h0, 5'h1f, "time-sync link");
		fset(16'h0008, 9'h1ff, 9'h0, 9'h0, 2'h2, 5'h1f, "gigabit");
		fset(16'h0008, 9'h1ff, 9'h0, 9'h0, 2'h1, 5'h0, "not gigabit");
		fset(16'h0004, 9'h1ff, 9'h0, 9'h0, 2'h3, 5'h1f, "200M");
		fset(16'h0002, 9'h1ff, 9'h0, 9'h0, 2'h0, 5'h1f, "10M");
		fset(16'h0000, 9'h1ff, 9'h1ff, 9'h1ff, 2'h2, 5'h0, "no source");
		fset(16'h2000, 9'h1ff, 9'h0, 9'h0, 2'h1, 5'h1f, "link idle");
		act_i <= 9'h1ff;
		for (int n = 0; n < 8; n++) begin
			wr(PIL_ADDR_CFG, 32'h80 | n);
			span();
			chk(32'(c), 32'((n == 0 ? 2 : n + 1) * UNIT), "period");
		end
		wr(PIL_ADDR_CFG, 32'h81);
		wr(PIL_ADDR_SETA, 32'h1000);
		span();
		chk(32'(c), 32'(2 * UNIT), "100M blink");
		auto_mode_i <= 1'h1;
		speed_i <= {9{PIL_SPD_10}};
		span();
		chk(32'(c), 32'(8 * UNIT), "10M quarter blink");
		print_verdict();
	end
endmodule
